// [core/scdc_regs.vh]
// Register map, reset values, field positions and wait counts of the
// clock control block. Definitions only; included by the control core file.
`ifndef SCDC_REGS_VH
`define SCDC_REGS_VH

// Register addresses on the 16-bit special function register port
`define SCDC_ADDR_SLOW_OSC_MODE 16'hff58
`define SCDC_ADDR_PERIPH_PRESCALE 16'hfff3
`define SCDC_ADDR_STOP_WAKE_WAIT 16'hfff4
`define SCDC_ADDR_CPU_DIVIDE 16'hfffb

// Reset values
`define SCDC_RST_SLOW_OSC_MODE 8'h00
`define SCDC_RST_PERIPH_PRESCALE 8'h02
`define SCDC_RST_CPU_DIVIDE 8'h02

// Field positions
`define SCDC_CPU_DIV_BIT 1
`define SCDC_PRESCALE_BIT0 0
`define SCDC_PRESCALE_BIT1 1
`define SCDC_SLOW_OSC_HALT 0
`define SCDC_WAIT_SEL_LSB 0
`define SCDC_WAIT_SEL_MSB 1

// Writable bit masks; every other bit reads as zero
`define SCDC_MASK_CPU_DIVIDE 8'h02
`define SCDC_MASK_PERIPH_PRESCALE 8'h03
`define SCDC_MASK_SLOW_OSC_MODE 8'h01
`define SCDC_MASK_STOP_WAKE_WAIT 8'h03

// Peripheral prescale register values
`define SCDC_PRESCALE_DIV1 8'h00
`define SCDC_PRESCALE_DIV2 8'h01
`define SCDC_PRESCALE_DIV4 8'h02

// System clock source codes of the option byte
`define SCDC_SRC_HS_INTERNAL 2'h0
`define SCDC_SRC_CRYSTAL 2'h1
`define SCDC_SRC_EXTERNAL 2'h2

// Stabilization waits in system clock periods (2^10, 2^12, 2^15, 2^17)
`define SCDC_WAIT_CODE0 1024
`define SCDC_WAIT_CODE1 4096
`define SCDC_WAIT_CODE2 32768
`define SCDC_WAIT_CODE3 131072

// Fastest instruction length in CPU clock periods
`define SCDC_MIN_INSTR_CPU_CLOCKS 6'h02

`endif

// [core/scdc_divider.v]
// Power-of-two clock enable divider: one-cycle tick every 2^ratio_log2
// system clocks while run is high.
// Assumes one clock, synchronous active-low reset, ratio_log2 up to 4.
`timescale 1ns/1ps

module scdc_divider #(
    parameter CNT_W = 4
) (
    clk,
    resetn,
    run,
    ratio_log2,
    tick
);
    input wire clk;
    input wire resetn;
    input wire run;
    input wire [2:0] ratio_log2;
    output reg tick;

    reg [CNT_W-1:0] count; // Free counter of system clocks
    wire [CNT_W:0] span; // 2^ratio_log2
    wire [CNT_W-1:0] last; // Terminal count

    assign span = {{CNT_W{1'b0}}, 1'b1} << ratio_log2;
    assign last = span[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};

    // Pulse at the terminal value; a count already past a new lower one wraps at once
    always @(posedge clk) begin
        if (!resetn) begin
            count <= {CNT_W{1'b0}};
            tick <= 1'b0;
        end else if (!run) begin
            // Held: no ticks, restart from zero on resume
            count <= {CNT_W{1'b0}};
            tick <= 1'b0;
        end else if (count >= last) begin
            count <= {CNT_W{1'b0}};
            tick <= 1'b1;
        end else begin
            count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
            tick <= 1'b0;
        end
    end
endmodule

// [core/scdc_ctrl.v]
// Clock control block: CPU and peripheral clock enables, low-speed
// oscillator gating and STOP-release stabilization wait.
// Assumes clk is the selected system clock and the option byte inputs
// are stable from reset; registers sit on a byte-wide SFR port.
//
// What this block does
// - Reset loads both divider registers with 02H
// - CPU clock divides per prescale and divide bits
// - Peripheral clock divides by 1, 2 or 4
// - Fastest instruction takes two CPU clocks
// - Reset clears slow oscillator mode register
// - Halt bit stops slow oscillator when permitted
// - When forbidden, oscillator runs, watchdog uses it
// - Wait select picks 2^10/12/15/17 clocks
// - Wait applies only for crystal source
// - STOP wait counts only after oscillation starts; boot wait counts at once
// - Wait select register undefined after reset
// - Boot source and wait from option byte
`timescale 1ns/1ps
`include "scdc_regs.vh"

module scdc_ctrl #(
    parameter WAIT_CODE0 = `SCDC_WAIT_CODE0,
    parameter WAIT_CODE1 = `SCDC_WAIT_CODE1,
    parameter WAIT_CODE2 = `SCDC_WAIT_CODE2,
    parameter WAIT_CODE3 = `SCDC_WAIT_CODE3,
    parameter WAIT_W = 18
) (
    clk,
    resetn,
    sfr_addr,
    sfr_wdata,
    sfr_wmask,
    sfr_wr,
    sfr_rd,
    sfr_rdata,
    sfr_hit,
    opt_src_sel,
    opt_boot_wait_sel,
    opt_slow_soft_stop,
    stop_release,
    osc_started,
    cpu_clk_en,
    periph_clk_en,
    min_instr_clocks,
    slow_osc_run,
    watchdog_src_fixed,
    clock_hold
);
    input wire clk;
    input wire resetn;
    input wire [15:0] sfr_addr;
    input wire [7:0] sfr_wdata;
    input wire [7:0] sfr_wmask;
    input wire sfr_wr;
    input wire sfr_rd;
    output reg [7:0] sfr_rdata;
    output reg sfr_hit;
    input wire [1:0] opt_src_sel;
    input wire [1:0] opt_boot_wait_sel;
    input wire opt_slow_soft_stop;
    input wire stop_release;
    input wire osc_started;
    output wire cpu_clk_en;
    output wire periph_clk_en;
    output reg [5:0] min_instr_clocks;
    output reg slow_osc_run;
    output reg watchdog_src_fixed;
    output reg clock_hold;

    // Wait sequencer states
    localparam ST_BOOT = 2'h0; // First cycle after reset release
    localparam ST_RUN = 2'h1; // Clocks running
    localparam ST_OSC = 2'h2; // STOP released, oscillation not yet started
    localparam ST_COUNT = 2'h3; // Counting the stabilization wait

    reg [7:0] cpu_divide_ctrl; // CPU divide register
    reg [7:0] periph_prescale_ctrl; // Peripheral prescale register
    reg [7:0] slow_osc_mode; // Slow oscillator mode register
    reg [7:0] stop_wake_wait_select; // Stabilization select, no reset
    reg [1:0] state; // Sequencer state
    reg [1:0] next_state; // Next sequencer state
    reg [WAIT_W-1:0] wait_cnt; // Remaining wait cycles
    reg [WAIT_W-1:0] next_wait_cnt; // Next wait count
    reg [2:0] cpu_log2; // Applied CPU divide exponent
    reg [2:0] next_cpu_log2; // Decoded CPU divide exponent
    reg [2:0] periph_log2; // Decoded peripheral divide exponent
    reg [7:0] next_rdata; // Read mux result
    reg next_hit; // Address decode result
    wire [2:0] div_code; // {prescale_bit1, prescale_bit0, cpu_div_bit}
    wire wr_cpu; // Write strobe per register
    wire wr_pre;
    wire wr_slow;
    wire wr_wait;

    assign div_code = {periph_prescale_ctrl[`SCDC_PRESCALE_BIT1],
                       periph_prescale_ctrl[`SCDC_PRESCALE_BIT0],
                       cpu_divide_ctrl[`SCDC_CPU_DIV_BIT]};
    assign wr_cpu = sfr_wr && (sfr_addr == `SCDC_ADDR_CPU_DIVIDE);
    assign wr_pre = sfr_wr && (sfr_addr == `SCDC_ADDR_PERIPH_PRESCALE);
    assign wr_slow = sfr_wr && (sfr_addr == `SCDC_ADDR_SLOW_OSC_MODE);
    assign wr_wait = sfr_wr && (sfr_addr == `SCDC_ADDR_STOP_WAKE_WAIT);

    // Convert a two-bit select into a wait length in system clocks
    function [WAIT_W-1:0] wait_len;
        input [1:0] sel;
        begin
            case (sel)
                2'h0: wait_len = WAIT_CODE0[WAIT_W-1:0];
                2'h1: wait_len = WAIT_CODE1[WAIT_W-1:0];
                2'h2: wait_len = WAIT_CODE2[WAIT_W-1:0];
                default: wait_len = WAIT_CODE3[WAIT_W-1:0];
            endcase
        end
    endfunction

    // Divider and slow oscillator mode registers; bit writes come in through the write mask
    always @(posedge clk) begin
        if (!resetn) begin
            cpu_divide_ctrl <= `SCDC_RST_CPU_DIVIDE;
            periph_prescale_ctrl <= `SCDC_RST_PERIPH_PRESCALE;
            slow_osc_mode <= `SCDC_RST_SLOW_OSC_MODE;
        end else begin
            if (wr_cpu) begin
                // Only the divide bit is stored
                cpu_divide_ctrl <= ((cpu_divide_ctrl & ~sfr_wmask)
                    | (sfr_wdata & sfr_wmask)) & `SCDC_MASK_CPU_DIVIDE;
            end
            if (wr_pre) begin
                periph_prescale_ctrl <= ((periph_prescale_ctrl & ~sfr_wmask)
                    | (sfr_wdata & sfr_wmask)) & `SCDC_MASK_PERIPH_PRESCALE;
            end
            if (wr_slow) begin
                slow_osc_mode <= ((slow_osc_mode & ~sfr_wmask)
                    | (sfr_wdata & sfr_wmask)) & `SCDC_MASK_SLOW_OSC_MODE;
            end
        end
    end

    // Stabilization select: byte write, mask ignored, no reset value
    always @(posedge clk) begin
        if (wr_wait) begin
            stop_wake_wait_select <= sfr_wdata & `SCDC_MASK_STOP_WAKE_WAIT;
        end
    end

    // Decode the CPU and peripheral divide exponents
    always @* begin
        next_cpu_log2 = cpu_log2;
        case (div_code)
            // Codes are {prescale_bit1, prescale_bit0, cpu_div_bit}
            3'h0: next_cpu_log2 = 3'h0;
            3'h2: next_cpu_log2 = 3'h1;
            3'h1: next_cpu_log2 = 3'h2;
            3'h4: next_cpu_log2 = 3'h2;
            3'h3: next_cpu_log2 = 3'h3;
            3'h5: next_cpu_log2 = 3'h4;
            // Prohibited codes keep the last legal ratio
            default: next_cpu_log2 = cpu_log2;
        endcase
        case (periph_prescale_ctrl)
            `SCDC_PRESCALE_DIV1: periph_log2 = 3'h0;
            `SCDC_PRESCALE_DIV2: periph_log2 = 3'h1;
            `SCDC_PRESCALE_DIV4: periph_log2 = 3'h2;
            // Value 03H falls back to the slowest peripheral ratio
            default: periph_log2 = 3'h2;
        endcase
    end

    // Applied ratio and instruction time in system clocks
    always @(posedge clk) begin
        if (!resetn) begin
            cpu_log2 <= 3'h1; // Divide by 2; reset code 101 selects divide by 16 from the next cycle
            min_instr_clocks <= 6'h00;
        end else begin
            cpu_log2 <= next_cpu_log2;
            // Two CPU clock periods per fastest instruction; the shift
            // tops out at 32 system clocks for the divide by 16 code
            min_instr_clocks <= `SCDC_MIN_INSTR_CPU_CLOCKS << next_cpu_log2;
        end
    end

    // Slow oscillator gate and watchdog source
    always @(posedge clk) begin
        if (!resetn) begin
            slow_osc_run <= 1'b1;
            watchdog_src_fixed <= 1'b0;
        end else if (opt_slow_soft_stop) begin
            slow_osc_run <= ~slow_osc_mode[`SCDC_SLOW_OSC_HALT];
            watchdog_src_fixed <= 1'b0;
        end else begin
            slow_osc_run <= 1'b1;
            watchdog_src_fixed <= 1'b1;
        end
    end

    // Wait sequencer: boot wait from option byte, STOP wait from register
    always @* begin
        next_state = state;
        next_wait_cnt = wait_cnt;
        case (state)
            ST_BOOT: begin
                if (opt_src_sel == `SCDC_SRC_CRYSTAL) begin
                    next_wait_cnt = wait_len(opt_boot_wait_sel);
                    next_state = ST_COUNT;
                end else begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (stop_release && (opt_src_sel == `SCDC_SRC_CRYSTAL)) begin
                    next_state = ST_OSC;
                end
            end
            ST_OSC: begin
                // Startup interval is not part of the wait
                if (osc_started) begin
                    next_wait_cnt = wait_len(stop_wake_wait_select[1:0]);
                    next_state = ST_COUNT;
                end
            end
            default: begin
                if (wait_cnt <= {{(WAIT_W-1){1'b0}}, 1'b1}) begin
                    next_wait_cnt = {WAIT_W{1'b0}};
                    next_state = ST_RUN;
                end else begin
                    next_wait_cnt = wait_cnt - {{(WAIT_W-1){1'b0}}, 1'b1};
                end
            end
        endcase
    end

    // Sequencer registers and CPU hold
    always @(posedge clk) begin
        if (!resetn) begin
            state <= ST_BOOT;
            wait_cnt <= {WAIT_W{1'b0}};
            clock_hold <= 1'b1;
        end else begin
            state <= next_state;
            wait_cnt <= next_wait_cnt;
            clock_hold <= (next_state != ST_RUN);
        end
    end

    // Register read port; fixed zero bits read as zero
    always @* begin
        next_hit = 1'b1;
        if (sfr_addr == `SCDC_ADDR_CPU_DIVIDE) begin
            next_rdata = cpu_divide_ctrl;
        end else if (sfr_addr == `SCDC_ADDR_PERIPH_PRESCALE) begin
            next_rdata = periph_prescale_ctrl;
        end else if (sfr_addr == `SCDC_ADDR_SLOW_OSC_MODE) begin
            next_rdata = slow_osc_mode;
        end else if (sfr_addr == `SCDC_ADDR_STOP_WAKE_WAIT) begin
            next_rdata = stop_wake_wait_select & `SCDC_MASK_STOP_WAKE_WAIT;
        end else begin
            // Unmapped address reads zero and is not claimed
            next_rdata = 8'h00;
            next_hit = 1'b0;
        end
    end

    // Registered read answer, one cycle after the read strobe
    always @(posedge clk) begin
        if (!resetn) begin
            sfr_rdata <= 8'h00;
            sfr_hit <= 1'b0;
        end else if (sfr_rd) begin
            sfr_rdata <= next_rdata;
            sfr_hit <= next_hit;
        end else begin
            sfr_rdata <= 8'h00;
            sfr_hit <= 1'b0;
        end
    end

    // CPU clock enable, stalled while a stabilization wait runs
    scdc_divider #(
        .CNT_W(4)
    ) u_cpu_div (
        .clk(clk),
        .resetn(resetn),
        .run(~clock_hold),
        .ratio_log2(cpu_log2),
        .tick(cpu_clk_en)
    );

    // Peripheral clock enable
    scdc_divider #(
        .CNT_W(4)
    ) u_periph_div (
        .clk(clk),
        .resetn(resetn),
        .run(~clock_hold),
        .ratio_log2(periph_log2),
        .tick(periph_clk_en)
    );
endmodule

// [bench/scdc_checker.sv]
// Concurrent checks on the ports of the clock control block.
// Assumes option inputs stay still between resets, short sim waits.
`timescale 1ns/1ps

module scdc_checker (
    input wire clk,
    input wire resetn,
    input wire [15:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    input wire [7:0] sfr_wmask,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_rdata,
    input wire sfr_hit,
    input wire [1:0] opt_src_sel,
    input wire opt_slow_soft_stop,
    input wire stop_release,
    input wire cpu_clk_en,
    input wire [5:0] min_instr_clocks,
    input wire slow_osc_run,
    input wire watchdog_src_fixed,
    input wire clock_hold
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // Read of the CPU divide register
    sequence s_cpu_rd;
        sfr_rd && sfr_addr == 16'hfffb;
    endsequence
    // Write that sets the slow oscillator halt bit
    sequence s_halt_wr;
        sfr_wr && sfr_addr == 16'hff58 && sfr_wmask[0] && sfr_wdata[0];
    endsequence
    // STOP release with the crystal source
    sequence s_xtal_wake;
        stop_release && opt_src_sel == 2'h1;
    endsequence

    chk_zero_bits: assert property (s_cpu_rd |=> sfr_hit && sfr_rdata[7:2] == 6'h00 && !sfr_rdata[0])
        else $error("fixed zero bits read nonzero");
    chk_unmapped_read: assert property (sfr_rd && !(sfr_addr inside {16'hff58, 16'hfff3,
        16'hfff4, 16'hfffb}) |=> !sfr_hit && sfr_rdata == 8'h00)
        else $error("unmapped read answered");
    chk_reset_state: assert property (disable iff (1'b0)
        !resetn |=> clock_hold && slow_osc_run && !cpu_clk_en)
        else $error("reset state wrong");
    chk_slow_halt: assert property (s_halt_wr ##0 opt_slow_soft_stop |=> ##[0:1] !slow_osc_run)
        else $error("slow oscillator not halted");
    chk_slow_forbid: assert property (!opt_slow_soft_stop |=> slow_osc_run && watchdog_src_fixed)
        else $error("slow oscillator stop not ignored");
    chk_no_wait: assert property ($past(resetn, 3) && opt_src_sel != 2'h1 |-> !clock_hold)
        else $error("hold without crystal");
    chk_ratio_legal: assert property ($past(resetn, 3) |-> min_instr_clocks inside {6'd2, 6'd4,
        6'd8, 6'd16, 6'd32})
        else $error("instruction length illegal");
    chk_cpu_gap: assert property (cpu_clk_en && min_instr_clocks > 6'd2 && $stable(min_instr_clocks)
        |=> !cpu_clk_en)
        else $error("cpu tick too close");
    chk_crystal_hold: assert property (s_xtal_wake |=> ##1 clock_hold [*4])
        else $error("crystal wake hold too short");
endmodule

bind scdc_ctrl scdc_checker i_chk (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wmask(sfr_wmask), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .opt_src_sel(opt_src_sel),
    .opt_slow_soft_stop(opt_slow_soft_stop), .stop_release(stop_release),
    .cpu_clk_en(cpu_clk_en), .min_instr_clocks(min_instr_clocks), .slow_osc_run(slow_osc_run),
    .watchdog_src_fixed(watchdog_src_fixed), .clock_hold(clock_hold));

// [bench/system_clock_divider_ctrl_tb.sv]
// Self-checking bench for the clock control block.
// Assumes the core files are compiled first; waits shortened to 4..32.
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks = num_checks + 1; if ((g) !== (e)) begin fails = fails + 1; \
    $display("mismatch %s exp %h got %h", n, e, g); end end

module system_clock_divider_ctrl_tb;
    reg clk = 1'b0;
    reg resetn = 1'b0;
    reg [15:0] sfr_addr = 16'h0000;
    reg [7:0] sfr_wdata = 8'h00;
    reg [7:0] sfr_wmask = 8'h00;
    reg sfr_wr = 1'b0;
    reg sfr_rd = 1'b0;
    reg [1:0] opt_src_sel = 2'h1;
    reg [1:0] opt_boot_wait_sel = 2'h1;
    reg opt_slow_soft_stop = 1'b1;
    reg stop_release = 1'b0;
    reg osc_started = 1'b1;
    wire [7:0] sfr_rdata;
    wire sfr_hit;
    wire cpu_clk_en;
    wire periph_clk_en;
    wire [5:0] min_instr_clocks;
    wire slow_osc_run;
    wire watchdog_src_fixed;
    wire clock_hold;
    integer fails = 0;
    integer num_checks = 0;
    integer n, nc, np, pp, cd, s;

    // 250 MHz system clock
    always #2 clk = ~clk;

    scdc_ctrl #(.WAIT_CODE0(4), .WAIT_CODE1(8), .WAIT_CODE2(16), .WAIT_CODE3(32)) i_dut (
        .clk(clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_wmask(sfr_wmask), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .sfr_hit(sfr_hit), .opt_src_sel(opt_src_sel), .opt_boot_wait_sel(opt_boot_wait_sel),
        .opt_slow_soft_stop(opt_slow_soft_stop), .stop_release(stop_release),
        .osc_started(osc_started), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
        .min_instr_clocks(min_instr_clocks), .slow_osc_run(slow_osc_run),
        .watchdog_src_fixed(watchdog_src_fixed), .clock_hold(clock_hold));

    // Prints the counts and the verdict, then stops
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", num_checks, fails);
            if (fails == 0 && num_checks > 0) begin
                $display("STATUS OK");
            end else begin
                $display("STATUS NOT OK");
            end
            $finish;
        end
    endtask

    // One write cycle on the register port
    task wr(input [15:0] a, input [7:0] d, input [7:0] m);
        begin
            @(negedge clk);
            sfr_addr = a;
            sfr_wdata = d;
            sfr_wmask = m;
            sfr_wr = 1'b1;
            @(negedge clk);
            sfr_wr = 1'b0;
        end
    endtask

    // One read cycle; data and hit are judged the cycle after
    task rd(input [15:0] a, input [7:0] e, input h);
        begin
            @(negedge clk);
            sfr_addr = a;
            sfr_rd = 1'b1;
            @(negedge clk);
            sfr_rd = 1'b0;
            `CHK("rdata", e, sfr_rdata)
            `CHK("hit", h, sfr_hit)
        end
    endtask

    // Counts cycles until the clock hold drops, bounded
    task hold_len;
        begin
            n = 0;
            while (clock_hold !== 1'b0 && n < 200) begin
                @(negedge clk);
                n = n + 1;
            end
        end
    endtask

    // Reset for 6 cycles, then time the boot hold
    task rst;
        begin
            resetn = 1'b0;
            repeat (6) @(negedge clk);
            resetn = 1'b1;
            @(negedge clk);
            hold_len;
        end
    endtask

    // One-cycle STOP release pulse
    task wake;
        begin
            @(negedge clk);
            stop_release = 1'b1;
            @(negedge clk);
            stop_release = 1'b0;
        end
    endtask

    // Main sequence
    initial begin
        rst;
        `CHK("boot wait", 1'b1, n >= 8 && n <= 12)
        rd(16'hfffb, 8'h02, 1'b1);
        rd(16'hfff3, 8'h02, 1'b1);
        rd(16'hff58, 8'h00, 1'b1);
        // Fixed zero bits and an unmapped place
        wr(16'hfffb, 8'hff, 8'hff);
        rd(16'hfffb, 8'h02, 1'b1);
        wr(16'hfff3, 8'hff, 8'hff);
        rd(16'hfff3, 8'h03, 1'b1);
        wr(16'hff58, 8'hfe, 8'hff);
        rd(16'hff58, 8'h00, 1'b1);
        wr(16'hff59, 8'hff, 8'hff);
        rd(16'hff59, 8'h00, 1'b0);
        // Every legal divide code, divide bit set by a bit write
        for (pp = 0; pp < 3; pp = pp + 1) begin
            for (cd = 0; cd < 2; cd = cd + 1) begin
                wr(16'hfff3, pp[7:0], 8'hff);
                wr(16'hfffb, {6'h00, cd[0], 1'b0}, 8'h02);
                repeat (40) @(negedge clk);
                nc = 0;
                np = 0;
                repeat (32) begin
                    @(negedge clk);
                    nc = nc + cpu_clk_en;
                    np = np + periph_clk_en;
                end
                `CHK("cpu ticks", 32 >> (pp + 2 * cd), nc)
                `CHK("periph ticks", 32 >> pp, np)
                `CHK("instr", 6'd2 << (pp + 2 * cd), min_instr_clocks)
            end
        end
        // Slow oscillator halt and restart by bit writes
        wr(16'hff58, 8'h01, 8'h01);
        repeat (3) @(negedge clk);
        `CHK("slow run", 1'b0, slow_osc_run)
        wr(16'hff58, 8'h00, 8'h01);
        repeat (3) @(negedge clk);
        `CHK("slow run", 1'b1, slow_osc_run)
        // Crystal wake for each wait code
        for (s = 0; s < 4; s = s + 1) begin
            wr(16'hfff4, {6'h3f, s[1:0]}, 8'hff);
            rd(16'hfff4, s[7:0], 1'b1);
            osc_started = 1'b0;
            wake;
            repeat (6) @(negedge clk);
            `CHK("hold before osc", 1'b1, clock_hold)
            osc_started = 1'b1;
            hold_len;
            `CHK("wake wait", 1'b1, n >= (4 << s) && n <= (4 << s) + 3)
        end
        // Internal and external sources with the stop forbidden
        opt_slow_soft_stop = 1'b0;
        for (s = 0; s < 3; s = s + 2) begin
            opt_src_sel = s[1:0];
            rst;
            `CHK("boot wait", 1'b1, n <= 3)
            rd(16'hfffb, 8'h02, 1'b1);
            wr(16'hff58, 8'h01, 8'hff);
            repeat (3) @(negedge clk);
            `CHK("slow run", 1'b1, slow_osc_run)
            `CHK("wd fixed", 1'b1, watchdog_src_fixed)
            wake;
            nc = 0;
            repeat (10) begin
                @(negedge clk);
                nc = nc + clock_hold;
            end
            `CHK("no wake hold", 0, nc)
        end
        end_sim;
    end

    // Hang guard, far beyond the expected run
    initial begin
        #40000;
        fails = fails + 1;
        end_sim;
    end
endmodule
